// file: pkg/ccss_defines.svh
// Timing, width and reset constants of the compressor capacity solenoid sequencer
`ifndef CCSS_DEFINES_SVH
`define CCSS_DEFINES_SVH

// Clock and the 1 ms time base
`define CCSS_CLK_NS 10
`define CCSS_TICK_NS 1000000
`define CCSS_TICK_CYC (`CCSS_TICK_NS / `CCSS_CLK_NS)

// Modulation period and pulse width limits
`define CCSS_PERIOD_S 10
`define CCSS_PERIOD_MS (`CCSS_PERIOD_S * 1000)
`define CCSS_PW_MIN_MS 40
`define CCSS_PW_MAX_MS 400

// Unload holds
`define CCSS_PWRUP_S 30
`define CCSS_PWRUP_MS (`CCSS_PWRUP_S * 1000)
`define CCSS_PRESTART_S 25
`define CCSS_PRESTART_MS (`CCSS_PRESTART_S * 1000)
`define CCSS_POSTSTART_S 30
`define CCSS_POSTSTART_MS (`CCSS_POSTSTART_S * 1000)
`define CCSS_PRESTOP_S 25
`define CCSS_PRESTOP_MS (`CCSS_PRESTOP_S * 1000)
`define CCSS_POSTSTOP_H 1
`define CCSS_POSTSTOP_MS (`CCSS_POSTSTOP_H * 3600 * 1000)

// Counter widths
`define CCSS_TMR_W 22
`define CCSS_PER_W 14
`define CCSS_PW_W 9
`define CCSS_ACC_W 16

// Field positions of the synchronised input word
`define CCSS_IN_RUN 0
`define CCSS_IN_LOAD 1
`define CCSS_IN_UNLOAD 2
`define CCSS_IN_LIMIT 3
`define CCSS_IN_PW_LSB 4
`define CCSS_IN_W 13

// Reset values of the outputs
`define CCSS_RST_UNLOAD 1'b1
`define CCSS_RST_LOAD 1'b0
`define CCSS_RST_UNLDR 1'b0
`define CCSS_RST_RUN 1'b0

`endif

// file: pkg/ccss_pkg.sv
// Types of the compressor capacity solenoid sequencer
`include "ccss_defines.svh"

package ccss_pkg;

  // Gray along power-up, idle, start, run, stop
  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_IDLE = 3'h1,
    ST_PRESTART = 3'h3,
    ST_POSTSTART = 3'h2,
    ST_STEADY = 3'h6,
    ST_PRESTOP = 3'h7
  } ccss_state_t;

  typedef struct packed {
    ccss_state_t st;
    logic [`CCSS_TMR_W-1:0] tmr;
    logic [`CCSS_PER_W-1:0] per;
    logic [`CCSS_PW_W-1:0] pw;
    logic dir_unl;
    logic [`CCSS_ACC_W-1:0] acc;
    logic hold;
    logic load;
    logic unload;
    logic unldr;
    logic run;
  } ccss_regs_t;

endpackage : ccss_pkg

// file: rtl/ccss_sync.sv
// Two-flop synchroniser for the pin inputs, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none

module ccss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          s1_q <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1_q <= d[i];
          q[i] <= s1_q;
        end
      end
    end
  endgenerate

endmodule : ccss_sync

`default_nettype wire

// file: rtl/ccss_tick.sv
// Divider that makes the one-cycle millisecond enable
`timescale 1ns/10ps
`default_nettype none

module ccss_tick #(
  parameter int unsigned DIV = 100000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Enable pulse
  output logic tick_q
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CW'(1);
      tick_q <= 1'b0;
    end
  end

endmodule : ccss_tick

`default_nettype wire

// file: rtl/ccss_seq.sv
// Load, unload and unloader solenoid sequencer of one screw compressor
//
// Behaviour
// R1 - In steady running at most one pulse of 40 to 400 ms is issued per 10 s period.
// R2 - A pulse drives load or unload, never both at once.
// R3 - Unload is held on continuously for 20 to 30 s just before a start and just before a stop.
// R4 - After a stop unload stays on for about one hour.
// R5 - After power-up reset unload is on continuously for 30 s.
// R6 - For 30 s after a start unload stays on and no load pulse is issued.
// R7 - When the post-start interval ends, pulsing begins and follows the temperature demand.
// R8 - With the setpoint met no pulse at all is issued in a period.
// R9 - The unloader is a steady level, set as the first loading step, released as the last.
// R10 - Modulating pulses are issued only while the compressor runs.
// R11 - An active limit condition suppresses load pulses even with demand present.
// R12 - A requested width above the maximum is clamped, one below the minimum gives no pulse.
`timescale 1ns/10ps
`default_nettype none
`include "ccss_defines.svh"

module ccss_seq
  import ccss_pkg::*;
#(
  parameter int unsigned P_TICK_CYC = `CCSS_TICK_CYC,
  parameter int unsigned P_PERIOD_MS = `CCSS_PERIOD_MS,
  parameter int unsigned P_PW_MIN_MS = `CCSS_PW_MIN_MS,
  parameter int unsigned P_PW_MAX_MS = `CCSS_PW_MAX_MS,
  parameter int unsigned P_PWRUP_MS = `CCSS_PWRUP_MS,
  parameter int unsigned P_PRESTART_MS = `CCSS_PRESTART_MS,
  parameter int unsigned P_POSTSTART_MS = `CCSS_POSTSTART_MS,
  parameter int unsigned P_PRESTOP_MS = `CCSS_PRESTOP_MS,
  parameter int unsigned P_POSTSTOP_MS = `CCSS_POSTSTOP_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Demand from the unit temperature control
  input wire logic run_req,
  input wire logic load_req,
  input wire logic unload_req,
  input wire logic limit_act,
  input wire logic [`CCSS_PW_W-1:0] pw_req,
  // Solenoid and motor drive
  output logic load_sol,
  output logic unload_sol,
  output logic unloader_sol,
  output logic comp_run,
  // Sequence state
  output logic [2:0] seq_state
);

  localparam int TW = `CCSS_TMR_W;
  localparam int PERW = `CCSS_PER_W;
  localparam int PWW = `CCSS_PW_W;
  localparam int AW = `CCSS_ACC_W;

  localparam ccss_regs_t RST = '{
    st: ST_PWRUP,
    tmr: '0,
    per: '0,
    pw: '0,
    dir_unl: 1'b0,
    acc: '0,
    hold: 1'b0,
    load: `CCSS_RST_LOAD,
    unload: `CCSS_RST_UNLOAD,
    unldr: `CCSS_RST_UNLDR,
    run: `CCSS_RST_RUN
  };

  ccss_regs_t q;
  ccss_regs_t n;
  logic tick;
  logic [`CCSS_IN_W-1:0] pins_s;
  logic run_s;
  logic load_s;
  logic unload_s;
  logic limit_s;
  logic [PWW-1:0] pw_s;
  logic [TW-1:0] lim;
  logic tmr_end;
  logic per_end;
  logic pw_ok;
  logic [PWW-1:0] width;

  // Demand comes from another board, so every pin is synchronised.
  // The width bus is only used at a period boundary, long after it has settled.
  ccss_sync #(
    .W(`CCSS_IN_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d({pw_req, limit_act, unload_req, load_req, run_req}),
    .q(pins_s)
  );

  assign run_s = pins_s[`CCSS_IN_RUN];
  assign load_s = pins_s[`CCSS_IN_LOAD];
  assign unload_s = pins_s[`CCSS_IN_UNLOAD];
  assign limit_s = pins_s[`CCSS_IN_LIMIT];
  assign pw_s = pins_s[`CCSS_IN_PW_LSB +: PWW];

  ccss_tick #(
    .DIV(P_TICK_CYC)
  ) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .tick_q(tick)
  );

  always_comb begin
    case (q.st)
      ST_PWRUP: lim = TW'(P_PWRUP_MS);
      ST_PRESTART: lim = TW'(P_PRESTART_MS);
      ST_POSTSTART: lim = TW'(P_POSTSTART_MS);
      ST_PRESTOP: lim = TW'(P_PRESTOP_MS);
      default: lim = TW'(P_POSTSTOP_MS);
    endcase
  end

  assign tmr_end = tick && (q.tmr == lim - TW'(1));
  assign per_end = tick && (q.per == PERW'(P_PERIOD_MS - 1));
  // Short requests are dropped, long ones clamped
  assign pw_ok = (pw_s >= PWW'(P_PW_MIN_MS)); // R12
  assign width = (pw_s > PWW'(P_PW_MAX_MS)) ? PWW'(P_PW_MAX_MS) : pw_s; // R12

  always_comb begin
    n = q;
    if (tick) begin
      n.tmr = q.tmr + TW'(1);
      n.per = per_end ? '0 : q.per + PERW'(1);
      if (q.pw != '0) begin
        n.pw = q.pw - PWW'(1);
      end
    end
    case (q.st)
      ST_PWRUP: begin
        if (tmr_end) begin // R5
          n.st = ST_IDLE;
          n.tmr = '0;
        end
      end
      ST_IDLE: begin
        if (q.hold && tmr_end) begin // R4
          n.hold = 1'b0;
        end
        if (run_s) begin
          n.st = ST_PRESTART;
          n.tmr = '0;
        end
      end
      ST_PRESTART: begin
        if (!run_s) begin
          n.st = ST_IDLE;
          n.hold = 1'b1;
          n.tmr = '0;
        end else if (tmr_end) begin // R3
          n.st = ST_POSTSTART;
          n.run = 1'b1;
          n.tmr = '0;
        end
      end
      ST_POSTSTART: begin
        if (!run_s) begin
          n.st = ST_PRESTOP;
          n.tmr = '0;
        end else if (tmr_end) begin // R6
          n.st = ST_STEADY; // R7
          n.per = '0;
          n.pw = '0;
        end
      end
      ST_STEADY: begin
        if (!run_s) begin
          n.st = ST_PRESTOP;
          n.tmr = '0;
          n.pw = '0;
        end else if (per_end) begin
          // Unload wins when both are asked; without demand nothing moves
          if (unload_s) begin // R2 R8
            if (q.unldr && q.acc == '0) begin
              n.unldr = 1'b0; // R9
            end else if (pw_ok) begin
              n.pw = width;
              n.dir_unl = 1'b1;
              n.acc = (q.acc > AW'(width)) ? q.acc - AW'(width) : '0;
            end
          end else if (load_s && !limit_s) begin // R11
            if (!q.unldr) begin
              n.unldr = 1'b1; // R9
            end else if (pw_ok) begin
              n.pw = width;
              n.dir_unl = 1'b0;
              n.acc = (q.acc > ~AW'(width)) ? '1 : q.acc + AW'(width);
            end
          end
        end
      end
      ST_PRESTOP: begin
        n.pw = '0;
        if (tmr_end) begin // R3
          n.st = ST_IDLE;
          n.run = 1'b0;
          n.hold = 1'b1; // R4
          n.unldr = 1'b0;
          n.acc = '0;
          n.tmr = '0;
        end
      end
      default: begin
        n = RST;
      end
    endcase
    // Pulses only in steady running, so start and stop holds can never see a load
    n.load = (n.st == ST_STEADY) && (n.pw != '0) && !n.dir_unl; // R1 R2 R10
    n.unload = (n.st == ST_STEADY) ? ((n.pw != '0) && n.dir_unl) // R1 R10
             : (n.st != ST_IDLE) || n.hold; // R3 R4 R5 R6
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign load_sol = q.load;
  assign unload_sol = q.unload;
  assign unloader_sol = q.unldr;
  assign comp_run = q.run;
  assign seq_state = q.st;

  // Helpers for the checks below
  logic pulse_on;
  logic [PWW:0] hi_ms_q;
  logic [PERW:0] gap_ms_q;

  assign pulse_on = q.load || (q.st == ST_STEADY && q.unload);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hi_ms_q <= '0;
      gap_ms_q <= '1;
    end else begin
      if (!pulse_on) begin
        hi_ms_q <= '0;
      end else if (tick) begin
        hi_ms_q <= hi_ms_q + (PWW + 1)'(1);
      end
      if (pulse_on && !$past(pulse_on)) begin
        gap_ms_q <= '0;
      end else if (tick && gap_ms_q != '1) begin
        gap_ms_q <= gap_ms_q + (PERW + 1)'(1);
      end
    end
  end

  sol_excl_a: // R2
    assert property (@(posedge ref_clk) disable iff (srst) !(load_sol && unload_sol))
    else $error("load and unload energised together");

  pulse_width_a: // R1
    assert property (@(posedge ref_clk) disable iff (srst)
      pulse_on |-> hi_ms_q <= (PWW + 1)'(P_PW_MAX_MS))
    else $error("pulse longer than the maximum width");

  pulse_period_a: // R1
    assert property (@(posedge ref_clk) disable iff (srst)
      $rose(pulse_on) |-> gap_ms_q >= (PERW + 1)'(P_PERIOD_MS))
    else $error("two pulses within one period");

  pwrup_unload_a: // R5
    assert property (@(posedge ref_clk) disable iff (srst)
      q.st == ST_PWRUP |-> unload_sol && !load_sol && !comp_run)
    else $error("unload not held after power-up");

  start_stop_a: // R3
    assert property (@(posedge ref_clk) disable iff (srst)
      q.st inside {ST_PRESTART, ST_PRESTOP} |-> unload_sol && !load_sol)
    else $error("unload not held around start or stop");

  post_start_a: // R6
    assert property (@(posedge ref_clk) disable iff (srst)
      q.st == ST_POSTSTART |-> unload_sol && !load_sol && comp_run)
    else $error("load or no unload after start");

  steady_entry_a: // R7
    assert property (@(posedge ref_clk) disable iff (srst)
      (q.st == ST_POSTSTART) ##1 (q.st != ST_POSTSTART)
      |-> q.st inside {ST_STEADY, ST_PRESTOP})
    else $error("post-start interval left to a wrong state");

  stop_hold_a: // R4
    assert property (@(posedge ref_clk) disable iff (srst)
      ($past(q.st) == ST_PRESTOP && q.st == ST_IDLE) |-> unload_sol [*8])
    else $error("unload dropped right after a stop");

  run_only_a: // R10
    assert property (@(posedge ref_clk) disable iff (srst)
      pulse_on |-> comp_run && q.st == ST_STEADY)
    else $error("pulse while compressor not running");

  limit_block_a: // R11
    assert property (@(posedge ref_clk) disable iff (srst)
      $rose(load_sol) |-> !$past(limit_s) && !$past(unload_s))
    else $error("load pulse under a limit condition");

  demand_only_a: // R8
    assert property (@(posedge ref_clk) disable iff (srst)
      $rose(pulse_on) |-> $past(load_s) || $past(unload_s))
    else $error("pulse without demand");

  min_width_a: // R12
    assert property (@(posedge ref_clk) disable iff (srst)
      $rose(pulse_on) |-> $past(pw_s) >= PWW'(P_PW_MIN_MS))
    else $error("pulse from a request below the minimum");

  unloader_step_a: // R9
    assert property (@(posedge ref_clk) disable iff (srst)
      ($rose(unloader_sol) || $fell(unloader_sol)) && q.st == ST_STEADY
      |-> !load_sol && !unload_sol)
    else $error("unloader changed together with a pulse");

endmodule : ccss_seq

`default_nettype wire

// file: tb/ccss_valves.sv
// Solenoid valve bank model that times every energised interval
`timescale 1ns/10ps
`default_nettype none

module ccss_valves (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Solenoid drive
  input wire logic load_sol,
  input wire logic unload_sol,
  // Pulse record
  output logic [15:0] n_pulse,
  output logic [15:0] last_w,
  output logic last_unl,
  output logic both_on
);
  logic [15:0] len;
  logic act_q;
  logic unl_q;

  // Coils only see on and off, so an interval is timed from rise to fall
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      n_pulse <= 16'h0;
      last_w <= 16'h0;
      last_unl <= 1'b0;
      both_on <= 1'b0;
      len <= 16'h0;
      act_q <= 1'b0;
      unl_q <= 1'b0;
    end else begin
      both_on <= both_on | (load_sol & unload_sol);
      act_q <= load_sol | unload_sol;
      unl_q <= unload_sol;
      len <= (load_sol | unload_sol) ? len + 16'h1 : 16'h0;
      if (act_q && !(load_sol | unload_sol)) begin
        n_pulse <= n_pulse + 16'h1;
        last_w <= len;
        last_unl <= unl_q;
      end
    end
  end
endmodule : ccss_valves

`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the solenoid sequencer
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int TK = 4;
  // Shortened timing so that every hold fits in a short run
  localparam int PER = 20;
  localparam int PMIN = 2;
  localparam int PMAX = 6;
  localparam int HOLD = 10;
  localparam int PSTOP = 30;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic run_req = 1'b0;
  logic load_req = 1'b0;
  logic unload_req = 1'b0;
  logic limit_act = 1'b0;
  logic [8:0] pw_req = 9'h000;
  logic load_sol;
  logic unload_sol;
  logic unloader_sol;
  logic comp_run;
  logic [2:0] seq_state;
  logic [15:0] n_pulse;
  logic [15:0] last_w;
  logic last_unl;
  logic both_on;
  int err_count = 0;
  int n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  ccss_seq #(.P_TICK_CYC(TK), .P_PERIOD_MS(PER), .P_PW_MIN_MS(PMIN), .P_PW_MAX_MS(PMAX),
    .P_PWRUP_MS(HOLD), .P_PRESTART_MS(HOLD), .P_POSTSTART_MS(HOLD), .P_PRESTOP_MS(HOLD),
    .P_POSTSTOP_MS(PSTOP)) uut (
    .ref_clk(ref_clk), .srst(srst), .run_req(run_req), .load_req(load_req),
    .unload_req(unload_req), .limit_act(limit_act), .pw_req(pw_req),
    .load_sol(load_sol), .unload_sol(unload_sol), .unloader_sol(unloader_sol),
    .comp_run(comp_run), .seq_state(seq_state));

  ccss_valves valves (.ref_clk(ref_clk), .srst(srst), .load_sol(load_sol),
    .unload_sol(unload_sol), .n_pulse(n_pulse), .last_w(last_w),
    .last_unl(last_unl), .both_on(both_on));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_st(input logic [2:0] st);
    int i;
    for (i = 0; i < 300 && seq_state !== st; i++) @(negedge ref_clk);
    chk(seq_state, st);
  endtask : wait_st

  // Counts the cycles spent in a hold state, unload on and load off throughout
  task automatic hold(input logic [2:0] st);
    int n;
    n = 0;
    while (seq_state === st && n < 2000) begin
      chk(unload_sol, 1'b1);
      chk(load_sol, 1'b0);
      n++;
      @(negedge ref_clk);
    end
    chk(n >= HOLD * TK - 4 && n <= HOLD * TK + 4, 1'b1);
  endtask : hold

  // Waits for the next modulating pulse; width zero means none may come
  task automatic pulse(input logic unl, input int w);
    logic [15:0] n0;
    int i;
    n0 = n_pulse;
    for (i = 0; i < 400 && n_pulse === n0; i++) @(negedge ref_clk);
    load_req = 1'b0;
    unload_req = 1'b0;
    limit_act = 1'b0;
    if (w == 0) begin
      chk(n_pulse, n0);
    end else begin
      chk(n_pulse, n0 + 16'h1);
      chk(last_w, w * TK);
      chk(last_unl, unl);
    end
    // One edge between clearing the demand and the next request
    @(negedge ref_clk);
  endtask : pulse

  task automatic t_power;
    chk(seq_state, 3'h0);
    hold(3'h0);
    chk(seq_state, 3'h1);
    chk(unload_sol, 1'b0);
    $display("test power done");
  endtask : t_power

  task automatic t_start;
    run_req = 1'b1;
    wait_st(3'h3);
    hold(3'h3);
    chk(comp_run, 1'b1);
    chk(seq_state, 3'h2);
    hold(3'h2);
    chk(seq_state, 3'h6);
    chk(unload_sol, 1'b0);
    // The model closes the start hold interval one edge later
    @(negedge ref_clk);
    $display("test start done");
  endtask : t_start

  task automatic t_modulate;
    int i;
    logic [15:0] n0;
    pulse(1'b0, 0);
    n0 = n_pulse;
    load_req = 1'b1;
    pw_req = 9'h004;
    for (i = 0; i < 200 && unloader_sol !== 1'b1; i++) @(negedge ref_clk);
    chk(unloader_sol, 1'b1);
    chk(n_pulse, n0);
    pulse(1'b0, 4);
    load_req = 1'b1;
    pw_req = 9'h009;
    pulse(1'b0, PMAX);
    load_req = 1'b1;
    pw_req = 9'h001;
    pulse(1'b0, 0);
    load_req = 1'b1;
    limit_act = 1'b1;
    pw_req = 9'h004;
    pulse(1'b0, 0);
    load_req = 1'b1;
    unload_req = 1'b1;
    pw_req = 9'h003;
    pulse(1'b1, 3);
    chk(unloader_sol, 1'b1);
    // Unload the remaining 7 ms as a clamped 6 ms step and a 2 ms step, then the next unload step releases the unloader
    unload_req = 1'b1;
    pw_req = 9'h007;
    pulse(1'b1, PMAX);
    unload_req = 1'b1;
    pw_req = 9'h002;
    pulse(1'b1, 2);
    chk(unloader_sol, 1'b1);
    n0 = n_pulse;
    unload_req = 1'b1;
    for (i = 0; i < 200 && unloader_sol !== 1'b0; i++) @(negedge ref_clk);
    unload_req = 1'b0;
    chk(unloader_sol, 1'b0);
    chk(n_pulse, n0);
    chk(both_on, 1'b0);
    $display("test modulate done");
  endtask : t_modulate

  task automatic t_stop;
    int n;
    logic [15:0] n0;
    run_req = 1'b0;
    wait_st(3'h7);
    hold(3'h7);
    chk(seq_state, 3'h1);
    chk(comp_run, 1'b0);
    chk(unloader_sol, 1'b0);
    n0 = n_pulse;
    load_req = 1'b1;
    pw_req = 9'h004;
    n = 0;
    while (unload_sol === 1'b1 && n < 1000) begin
      chk(load_sol, 1'b0);
      n++;
      @(negedge ref_clk);
    end
    chk(n >= PSTOP * TK - 8 && n <= PSTOP * TK + 4, 1'b1);
    // The model counts the stop hold as closed one edge after it ends
    @(negedge ref_clk);
    chk(n_pulse, n0 + 16'h1);
    chk(load_sol, 1'b0);
    load_req = 1'b0;
    $display("test stop done");
  endtask : t_stop

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs about 2100 cycles
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    t_power();
    t_start();
    t_modulate();
    t_stop();
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
